// ==== hdl/uhp_defs.svh ====
`ifndef UHP_DEFS_SVH
`define UHP_DEFS_SVH

// widths
`define UHP_DATA_W 16
`define UHP_ADDR_W 4
`define UHP_EVT_W 5
`define UHP_HOST_CFG_W 5
`define UHP_PERIPH_CFG_W 3
`define UHP_STAT_W 3

// register offsets
`define UHP_OFF_HOST_CFG 4'h0
`define UHP_OFF_PERIPH_CFG 4'h1
`define UHP_OFF_IRQ_STATUS 4'h2
`define UHP_OFF_IRQ_MASK 4'h3
`define UHP_OFF_PORT_STATUS 4'h4

// reset values
`define UHP_HOST_CFG_RST 5'h00
`define UHP_PERIPH_CFG_RST 3'h0
`define UHP_IRQ_MASK_RST 5'h00
`define UHP_STROBE_RST 3'h7
`define UHP_GRANT_RST 2'h3
`define UHP_DATA_RST 16'h0000

// event bit positions
`define UHP_EVT_HOST_IRQ 0
`define UHP_EVT_PERIPH_IRQ 1
`define UHP_EVT_HOST_GRANT 2
`define UHP_EVT_PERIPH_GRANT 3
`define UHP_EVT_WR_ABORT 4

// grant pin positions
`define UHP_GNT_HOST 0
`define UHP_GNT_PERIPH 1

`endif

// ==== hdl/uhp_evt_reg.sv ====
`timescale 1ns/1ps
module uhp_evt_reg #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] MASK_RST = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // events and software access
  input wire logic [WIDTH-1:0] set_evt,
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [WIDTH-1:0] wdata,
  // state
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);
  wire [WIDTH-1:0] clr_bits = clr_wr ? wdata : '0;
  // set wins over a clear in the same cycle so no event is lost
  wire [WIDTH-1:0] next_status = (status & ~clr_bits) | set_evt;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status <= '0;
      mask <= MASK_RST;
    end else begin
      status <= next_status;
      if (mask_wr) begin
        mask <= wdata;
      end
    end
  end

  assign irq = |(status & mask);
endmodule : uhp_evt_reg

// ==== hdl/uhp_pkg.sv ====
package uhp_pkg;
  `include "uhp_defs.svh"

  typedef struct packed {
    logic merge_irq_lines;
    logic merge_dma_channels;
    logic irq_high;
    logic grant_high;
    logic req_high;
  } uhp_host_cfg_type;

  typedef struct packed {
    logic irq_high;
    logic grant_high;
    logic req_high;
  } uhp_periph_cfg_type;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } uhp_strobe_type;

  typedef struct packed {
    logic [`UHP_ADDR_W-1:0] addr;
    logic [`UHP_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } uhp_reg_req_type;

  typedef enum logic [2:0] {
    UHP_IDLE = 3'b001,
    UHP_READ = 3'b010,
    UHP_WRITE = 3'b100
  } uhp_state_type;
endpackage : uhp_pkg

// ==== hdl/uhp_port.sv ====
`timescale 1ns/1ps
`include "uhp_defs.svh"
module uhp_port #(
  parameter int DATA_W = `UHP_DATA_W,
  parameter int ADDR_W = `UHP_ADDR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // processor bus pins
  input wire uhp_pkg::uhp_strobe_type bus_strobe_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // dma pins
  output logic host_dma_request,
  output logic periph_dma_request,
  input wire logic host_dma_grant,
  input wire logic periph_dma_grant,
  // interrupt pins
  output logic host_irq,
  output logic periph_irq,
  // core access side
  output logic core_rd_strobe,
  input wire logic [DATA_W-1:0] core_rd_data,
  output logic core_wr_strobe,
  output logic [DATA_W-1:0] core_wr_data,
  // core dma and interrupt side
  input wire logic core_host_dma_need,
  input wire logic core_periph_dma_need,
  output logic core_host_dma_granted,
  output logic core_periph_dma_granted,
  input wire logic core_host_irq_req,
  input wire logic core_periph_irq_req,
  // configuration register port
  input wire uhp_pkg::uhp_reg_req_type reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  // summary interrupt
  output logic sys_irq
);
  import uhp_pkg::*;

  // pins leave reset inactive for whatever polarity the reset configuration selects
  localparam uhp_host_cfg_type HOST_CFG_RST = `UHP_HOST_CFG_RST;
  localparam uhp_periph_cfg_type PERIPH_CFG_RST = `UHP_PERIPH_CFG_RST;

  // settled pin levels
  uhp_strobe_type strobe_n;
  logic [1:0] grant_pin;
  logic [DATA_W-1:0] data_s;

  uhp_sync #(
    .WIDTH(3),
    .INIT(`UHP_STROBE_RST)
  ) u_strobe_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(bus_strobe_n),
    .level(strobe_n)
  );

  // grants reset to their pulled-up idle level so no false grant edge follows reset
  uhp_sync #(
    .WIDTH(2),
    .INIT(`UHP_GRANT_RST)
  ) u_grant_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({periph_dma_grant, host_dma_grant}),
    .level(grant_pin)
  );

  // data only needs to settle under the strobe, so per-bit agreement is enough
  uhp_sync #(
    .WIDTH(DATA_W),
    .INIT(`UHP_DATA_RST)
  ) u_data_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(data_in),
    .level(data_s)
  );

  // configuration registers
  uhp_host_cfg_type host_hw_config;
  uhp_periph_cfg_type periph_hw_config;

  wire sel_host_cfg = reg_req.addr == `UHP_OFF_HOST_CFG;
  wire sel_periph_cfg = reg_req.addr == `UHP_OFF_PERIPH_CFG;
  wire sel_status = reg_req.addr == `UHP_OFF_IRQ_STATUS;
  wire sel_mask = reg_req.addr == `UHP_OFF_IRQ_MASK;
  wire sel_port = reg_req.addr == `UHP_OFF_PORT_STATUS;
  wire wr_host_cfg = reg_req.wr & sel_host_cfg;
  wire wr_periph_cfg = reg_req.wr & sel_periph_cfg;
  wire wr_status = reg_req.wr & sel_status;
  wire wr_mask = reg_req.wr & sel_mask;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_hw_config <= `UHP_HOST_CFG_RST;
      periph_hw_config <= `UHP_PERIPH_CFG_RST;
    end else begin
      if (wr_host_cfg) begin
        host_hw_config <= reg_req.wdata[`UHP_HOST_CFG_W-1:0];
      end
      if (wr_periph_cfg) begin
        periph_hw_config <= reg_req.wdata[`UHP_PERIPH_CFG_W-1:0];
      end
    end
  end

  // access state machine
  uhp_state_type state;
  uhp_state_type next_state;
  logic rd_load;
  logic [DATA_W-1:0] wr_hold;

  wire selected = ~strobe_n.cs_n;
  wire rd_low = ~strobe_n.rd_n;
  wire wr_low = ~strobe_n.wr_n;
  // both strobes low is not legal on this bus; read is taken first
  wire start_rd = selected & rd_low;
  wire start_wr = selected & wr_low & ~rd_low;
  wire rd_end = ~selected | ~rd_low;
  wire wr_done = selected & ~wr_low;
  wire wr_abort = ~selected;

  always_comb begin
    next_state = state;
    case (state)
      UHP_IDLE: begin
        if (start_rd) begin
          next_state = UHP_READ;
        end else if (start_wr) begin
          next_state = UHP_WRITE;
        end
      end
      UHP_READ: begin
        if (rd_end) begin
          next_state = UHP_IDLE;
        end
      end
      UHP_WRITE: begin
        if (wr_done | wr_abort) begin
          next_state = UHP_IDLE;
        end
      end
      default: begin
        next_state = UHP_IDLE;
      end
    endcase
  end

  wire next_core_rd = (state == UHP_IDLE) & start_rd;
  wire next_core_wr = (state == UHP_WRITE) & wr_done;
  wire write_aborted = (state == UHP_WRITE) & wr_abort;
  // the bus is driven only in the read state and released as the strobe leaves
  wire next_oe = (next_state == UHP_READ);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= UHP_IDLE;
      core_rd_strobe <= 1'b0;
      core_wr_strobe <= 1'b0;
      rd_load <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      state <= next_state;
      core_rd_strobe <= next_core_rd;
      core_wr_strobe <= next_core_wr;
      rd_load <= core_rd_strobe;
      data_oe <= next_oe;
    end
  end

  // read data reaches the pins two cycles after the drive starts, long before the host samples
  // write data is the bus as last seen while the strobe was low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_hold <= `UHP_DATA_RST;
      core_wr_data <= `UHP_DATA_RST;
      data_out <= `UHP_DATA_RST;
    end else begin
      if (state == UHP_WRITE && wr_low) begin
        wr_hold <= data_s;
      end
      if (next_core_wr) begin
        core_wr_data <= wr_hold;
      end
      if (rd_load) begin
        data_out <= core_rd_data;
      end
    end
  end

  // dma routing
  wire merged_dma = host_hw_config.merge_dma_channels;
  wire host_side_need = core_host_dma_need | (merged_dma & core_periph_dma_need);
  wire periph_side_need = ~merged_dma & core_periph_dma_need;
  wire next_host_req_pin = host_hw_config.req_high ? host_side_need : ~host_side_need;
  wire next_periph_req_pin = periph_hw_config.req_high ? periph_side_need
                                                       : ~periph_side_need;

  wire host_gnt_raw = grant_pin[`UHP_GNT_HOST];
  wire periph_gnt_raw = grant_pin[`UHP_GNT_PERIPH];
  wire host_gnt_act = host_hw_config.grant_high ? host_gnt_raw : ~host_gnt_raw;
  wire periph_gnt_act = periph_hw_config.grant_high ? periph_gnt_raw
                                                    : ~periph_gnt_raw;
  // when merged the shared grant goes to the host channel first
  // the core must hold its need through a burst, or the shared grant may move
  wire next_host_granted = host_gnt_act & core_host_dma_need;
  wire merged_periph_gnt = host_gnt_act & ~core_host_dma_need & core_periph_dma_need;
  wire split_periph_gnt = periph_gnt_act & core_periph_dma_need;
  wire next_periph_granted = merged_dma ? merged_periph_gnt : split_periph_gnt;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_dma_request <= ~HOST_CFG_RST.req_high;
      periph_dma_request <= ~PERIPH_CFG_RST.req_high;
      core_host_dma_granted <= 1'b0;
      core_periph_dma_granted <= 1'b0;
    end else begin
      host_dma_request <= next_host_req_pin;
      periph_dma_request <= next_periph_req_pin;
      core_host_dma_granted <= next_host_granted;
      core_periph_dma_granted <= next_periph_granted;
    end
  end

  // event status, mask and the summary interrupt
  // sys_irq follows the masked status bits one cycle late, as the pins do
  logic [`UHP_EVT_W-1:0] irq_status;
  logic [`UHP_EVT_W-1:0] irq_mask;
  logic host_gnt_d;
  logic periph_gnt_d;
  logic [`UHP_EVT_W-1:0] evt_set;
  logic summary_irq;

  always_comb begin
    evt_set = '0;
    evt_set[`UHP_EVT_HOST_IRQ] = core_host_irq_req;
    evt_set[`UHP_EVT_PERIPH_IRQ] = core_periph_irq_req;
    evt_set[`UHP_EVT_HOST_GRANT] = next_host_granted & ~host_gnt_d;
    evt_set[`UHP_EVT_PERIPH_GRANT] = next_periph_granted & ~periph_gnt_d;
    evt_set[`UHP_EVT_WR_ABORT] = write_aborted;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_gnt_d <= 1'b0;
      periph_gnt_d <= 1'b0;
    end else begin
      host_gnt_d <= next_host_granted;
      periph_gnt_d <= next_periph_granted;
    end
  end

  uhp_evt_reg #(
    .WIDTH(`UHP_EVT_W),
    .MASK_RST(`UHP_IRQ_MASK_RST)
  ) u_evt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_evt(evt_set),
    .clr_wr(wr_status),
    .mask_wr(wr_mask),
    .wdata(reg_req.wdata[`UHP_EVT_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(summary_irq)
  );

  // interrupt pins follow the masked sticky controller bits
  wire host_irq_src = irq_status[`UHP_EVT_HOST_IRQ] & irq_mask[`UHP_EVT_HOST_IRQ];
  wire periph_irq_src = irq_status[`UHP_EVT_PERIPH_IRQ] & irq_mask[`UHP_EVT_PERIPH_IRQ];
  wire merged_irq = host_hw_config.merge_irq_lines;
  wire host_irq_act = host_irq_src | (merged_irq & periph_irq_src);
  wire periph_irq_act = ~merged_irq & periph_irq_src;
  wire next_host_irq_pin = host_hw_config.irq_high ? host_irq_act : ~host_irq_act;
  wire next_periph_irq_pin = periph_hw_config.irq_high ? periph_irq_act
                                                       : ~periph_irq_act;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_irq <= ~HOST_CFG_RST.irq_high;
      periph_irq <= ~PERIPH_CFG_RST.irq_high;
      sys_irq <= 1'b0;
    end else begin
      host_irq <= next_host_irq_pin;
      periph_irq <= next_periph_irq_pin;
      sys_irq <= summary_irq;
    end
  end

  // register read data, one cycle after the read strobe, zero elsewhere
  wire [`UHP_STAT_W-1:0] port_status = {periph_side_need, host_side_need, data_oe};
  wire [DATA_W-1:0] rd_host = {{(DATA_W-`UHP_HOST_CFG_W){1'b0}}, host_hw_config};
  wire [DATA_W-1:0] rd_periph = {{(DATA_W-`UHP_PERIPH_CFG_W){1'b0}}, periph_hw_config};
  wire [DATA_W-1:0] rd_status = {{(DATA_W-`UHP_EVT_W){1'b0}}, irq_status};
  wire [DATA_W-1:0] rd_mask = {{(DATA_W-`UHP_EVT_W){1'b0}}, irq_mask};
  wire [DATA_W-1:0] rd_port = {{(DATA_W-`UHP_STAT_W){1'b0}}, port_status};
  logic [DATA_W-1:0] rd_sel;

  // unmapped offsets and idle cycles read back as zero
  always_comb begin
    rd_sel = '0;
    if (!reg_req.rd) begin
      rd_sel = '0;
    end else if (sel_host_cfg) begin
      rd_sel = rd_host;
    end else if (sel_periph_cfg) begin
      rd_sel = rd_periph;
    end else if (sel_status) begin
      rd_sel = rd_status;
    end else if (sel_mask) begin
      rd_sel = rd_mask;
    end else if (sel_port) begin
      rd_sel = rd_port;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rd_sel;
    end
  end
endmodule : uhp_port

// ==== hdl/uhp_sync.sv ====
`timescale 1ns/1ps
module uhp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pin and settled level
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire [WIDTH-1:0] agree = ~(s2 ^ s3);
  wire [WIDTH-1:0] next_level = (agree & s2) | (~agree & level);

  // a bit counts only once the second and third stage agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule : uhp_sync

// ==== tb/tb_usb_otg_host_bus_dma_port.sv ====
`timescale 1ns/1ps
`include "uhp_defs.svh"
module tb_usb_otg_host_bus_dma_port;
  import uhp_pkg::*;
  logic sys_clk, rst_n, data_oe, host_dma_request, periph_dma_request, host_dma_grant;
  logic periph_dma_grant, host_irq, periph_irq, core_rd_strobe, core_wr_strobe, sys_irq;
  logic core_host_dma_need, core_periph_dma_need, core_host_dma_granted;
  logic core_periph_dma_granted, core_host_irq_req, core_periph_irq_req;
  logic [15:0] data_in, data_out, core_rd_data, core_wr_data, reg_rdata, last_wr, q;
  uhp_strobe_type bus_strobe_n;
  uhp_reg_req_type reg_req;
  int fails, n_compared, n_rd, n_wr;
  uhp_port dut_u (
    .sys_clk, .rst_n, .bus_strobe_n, .data_in, .data_out, .data_oe, .host_dma_request,
    .periph_dma_request, .host_dma_grant, .periph_dma_grant, .host_irq, .periph_irq,
    .core_rd_strobe, .core_rd_data, .core_wr_strobe, .core_wr_data, .core_host_dma_need,
    .core_periph_dma_need, .core_host_dma_granted, .core_periph_dma_granted,
    .core_host_irq_req, .core_periph_irq_req, .reg_req, .reg_rdata, .sys_irq
  );
  uhp_cpu_model u_cpu (
    .sys_clk, .bus_strobe_n, .bus_d(data_in), .data_out, .data_oe, .host_dma_grant,
    .periph_dma_grant
  );
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (core_rd_strobe === 1'b1) n_rd <= n_rd + 1;
    if (core_wr_strobe === 1'b1) n_wr <= n_wr + 1;
    if (core_wr_strobe === 1'b1) last_wr <= core_wr_data;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    reg_req <= '0;
    @(posedge sys_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 chk(reg_rdata, exp);
    @(posedge sys_clk);
  endtask : reg_rd
  task automatic pulse(input logic h);
    core_host_irq_req <= h;
    core_periph_irq_req <= !h;
    @(posedge sys_clk);
    core_host_irq_req <= 1'b0;
    core_periph_irq_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse
  task automatic t_bus;
    reg_rd(`UHP_OFF_HOST_CFG, 16'h0000);
    reg_rd(`UHP_OFF_IRQ_MASK, 16'h0000);
    u_cpu.cpu_read(1'b0, q);
    chk(q, 16'hC35A);
    chk({15'h0, data_oe}, 16'h0000);
    u_cpu.cpu_read(1'b1, q);
    chk(16'(n_rd), 16'h0001);
    u_cpu.cpu_write(16'hA55A);
    chk(last_wr, 16'hA55A);
    chk(16'(n_wr), 16'h0001);
    $display("bus test done");
  endtask : t_bus
  task automatic t_dma;
    for (int p = 0; p < 2; p++) begin
      reg_wr(`UHP_OFF_HOST_CFG, 16'(p * 3));
      reg_wr(`UHP_OFF_PERIPH_CFG, 16'(p * 3));
      core_host_dma_need <= 1'b1;
      core_periph_dma_need <= 1'b1;
      u_cpu.grant(p[0], p[0]);
      repeat (8) @(posedge sys_clk);
      chk(16'({host_dma_request, periph_dma_request}), 16'({2{p[0]}}));
      chk(16'({core_host_dma_granted, core_periph_dma_granted}), 16'h0003);
      reg_rd(`UHP_OFF_PORT_STATUS, 16'h0006);
      core_host_dma_need <= 1'b0;
      core_periph_dma_need <= 1'b0;
      u_cpu.grant(!p[0], !p[0]);
      repeat (8) @(posedge sys_clk);
      chk(16'({host_dma_request, periph_dma_request}), 16'({2{!p[0]}}));
      chk(16'({core_host_dma_granted, core_periph_dma_granted}), 16'h0000);
    end
    reg_wr(`UHP_OFF_HOST_CFG, 16'h0008);
    reg_wr(`UHP_OFF_PERIPH_CFG, 16'h0000);
    core_periph_dma_need <= 1'b1;
    u_cpu.grant(1'b0, 1'b1);
    repeat (8) @(posedge sys_clk);
    chk(16'({host_dma_request, periph_dma_request}), 16'h0001);
    chk(16'({core_host_dma_granted, core_periph_dma_granted}), 16'h0001);
    reg_rd(`UHP_OFF_PORT_STATUS, 16'h0002);
    core_periph_dma_need <= 1'b0;
    u_cpu.grant(1'b1, 1'b1);
    $display("dma test done");
  endtask : t_dma
  task automatic t_irq;
    reg_rd(`UHP_OFF_IRQ_STATUS, 16'h000C);
    reg_wr(`UHP_OFF_IRQ_STATUS, 16'h001F);
    reg_wr(`UHP_OFF_IRQ_MASK, 16'h0003);
    reg_wr(`UHP_OFF_HOST_CFG, 16'h0004);
    pulse(1'b1);
    chk(16'({host_irq, periph_irq, sys_irq}), 16'h0007);
    reg_rd(`UHP_OFF_IRQ_STATUS, 16'h0001);
    reg_wr(`UHP_OFF_IRQ_STATUS, 16'h0001);
    pulse(1'b0);
    chk(16'({host_irq, periph_irq}), 16'h0000);
    reg_wr(`UHP_OFF_PERIPH_CFG, 16'h0004);
    repeat (2) @(posedge sys_clk);
    chk(16'(periph_irq), 16'h0001);
    reg_wr(`UHP_OFF_PERIPH_CFG, 16'h0000);
    reg_wr(`UHP_OFF_HOST_CFG, 16'h0014);
    repeat (2) @(posedge sys_clk);
    chk(16'({host_irq, periph_irq}), 16'h0003);
    reg_wr(`UHP_OFF_IRQ_STATUS, 16'h0002);
    reg_wr(`UHP_OFF_IRQ_MASK, 16'h0000);
    pulse(1'b1);
    chk(16'({host_irq, sys_irq}), 16'h0000);
    reg_rd(`UHP_OFF_IRQ_STATUS, 16'h0001);
    reg_rd(4'hF, 16'h0000);
    $display("irq test done");
  endtask : t_irq
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done;
  end
  initial begin
    {fails, n_compared, n_rd, n_wr} = '0;
    rst_n = 1'b0;
    reg_req = '0;
    core_rd_data = 16'hC35A;
    {core_host_dma_need, core_periph_dma_need, core_host_irq_req, core_periph_irq_req} = '0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_bus;
    t_dma;
    t_irq;
    test_done;
  end
endmodule : tb_usb_otg_host_bus_dma_port
bind uhp_port uhp_port_props u_props (
  .sys_clk, .rst_n, .bus_strobe_n, .data_oe, .host_dma_request, .periph_dma_request,
  .periph_irq, .core_rd_strobe, .core_wr_strobe, .core_wr_data, .core_host_dma_need,
  .core_periph_dma_need, .core_host_dma_granted, .core_host_irq_req, .host_irq, .reg_req
);

// ==== tb/uhp_cpu_model.sv ====
`timescale 1ns/1ps
module uhp_cpu_model (
  // clock
  input wire logic sys_clk,
  // processor pins
  output uhp_pkg::uhp_strobe_type bus_strobe_n,
  output logic [15:0] bus_d,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  // dma controller pins
  output logic host_dma_grant,
  output logic periph_dma_grant
);
  import uhp_pkg::*;
  logic drv;
  logic tgl;
  logic [15:0] wdat;
  // a released bus toggles so a stale value can never pass for read data
  assign bus_d = data_oe ? data_out : (drv ? wdat : {16{tgl}});
  initial begin
    bus_strobe_n = 3'h7;
    drv = 1'b0;
    tgl = 1'b0;
    wdat = 16'h0000;
    host_dma_grant = 1'b1;
    periph_dma_grant = 1'b1;
  end
  always @(posedge sys_clk) tgl <= !tgl;
  // strobes never overlap and select covers each whole pulse, except a cpu_read called with sel_n high
  task automatic cpu_read(input logic sel_n, output logic [15:0] q);
    bus_strobe_n <= {sel_n, 1'b0, 1'b1};
    repeat (10) @(posedge sys_clk);
    q = bus_d;
    bus_strobe_n <= 3'h7;
    repeat (6) @(posedge sys_clk);
  endtask : cpu_read
  // data held until select drops, past the write strobe edge
  task automatic cpu_write(input logic [15:0] d);
    drv <= 1'b1;
    wdat <= d;
    bus_strobe_n <= 3'h2;
    repeat (6) @(posedge sys_clk);
    bus_strobe_n <= 3'h3;
    repeat (6) @(posedge sys_clk);
    bus_strobe_n <= 3'h7;
    drv <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : cpu_write
  // grant levels as given, polarity chosen by the caller
  task automatic grant(input logic h, input logic p);
    host_dma_grant <= h;
    periph_dma_grant <= p;
  endtask : grant
endmodule : uhp_cpu_model

// ==== tb/uhp_port_props.sv ====
`timescale 1ns/1ps
`include "uhp_defs.svh"
module uhp_port_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pin side
  input wire uhp_pkg::uhp_strobe_type bus_strobe_n,
  input wire logic data_oe,
  input wire logic host_dma_request,
  input wire logic periph_dma_request,
  input wire logic periph_irq,
  // core side
  input wire logic core_rd_strobe,
  input wire logic core_wr_strobe,
  input wire logic [15:0] core_wr_data,
  input wire logic core_host_dma_need,
  input wire logic core_periph_dma_need,
  input wire logic core_host_dma_granted,
  input wire logic core_host_irq_req,
  input wire logic host_irq,
  input wire uhp_pkg::uhp_reg_req_type reg_req
);
  import uhp_pkg::*;
  uhp_host_cfg_type hc;
  uhp_periph_cfg_type pc;
  logic msk0;
  logic [2:0] cs_hi;
  wire logic wr_h = reg_req.wr && reg_req.addr == `UHP_OFF_HOST_CFG;
  wire logic wr_p = reg_req.wr && reg_req.addr == `UHP_OFF_PERIPH_CFG;
  wire logic wr_m = reg_req.wr && reg_req.addr == `UHP_OFF_IRQ_MASK;
  wire logic [2:0] next_cs_hi = bus_strobe_n.cs_n ? cs_hi + {2'h0, cs_hi != 3'h7} : 3'h0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // shadow of software settings so pin polarity can be predicted
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hc <= '0;
      pc <= '0;
      msk0 <= 1'b0;
      cs_hi <= 3'h0;
    end else begin
      if (wr_h) hc <= reg_req.wdata[4:0];
      if (wr_p) pc <= reg_req.wdata[2:0];
      if (wr_m) msk0 <= reg_req.wdata[0];
      cs_hi <= next_cs_hi;
    end
  end
  sequence rd_start_s;
    core_rd_strobe && data_oe;
  endsequence
  oe_idle_a: assert property (cs_hi == 3'h7 |-> !data_oe && !core_rd_strobe && !core_wr_strobe)
    else $error("bus driven or access taken while deselected");
  rd_pulse_a: assert property (core_rd_strobe |-> rd_start_s ##1 !core_rd_strobe)
    else $error("read strobe without bus drive or too long");
  wr_hold_a: assert property (core_wr_strobe |=> $stable(core_wr_data))
    else $error("write data not held");
  host_req_a: assert property (host_dma_request == ($past(hc.req_high) ~^ ($past(core_host_dma_need)
    | $past(hc.merge_dma_channels) & $past(core_periph_dma_need))))
    else $error("host dma request level wrong");
  periph_req_a: assert property (periph_dma_request == ($past(hc.merge_dma_channels) ?
    !$past(pc.req_high) : ($past(pc.req_high) ~^ $past(core_periph_dma_need))))
    else $error("periph dma request level wrong");
  grant_need_a: assert property (core_host_dma_granted |-> $past(core_host_dma_need))
    else $error("host grant without need");
  host_irq_a: assert property (core_host_irq_req && msk0 |-> ##2 host_irq == hc.irq_high)
    else $error("host interrupt not raised");
  merge_irq_a: assert property ($past(hc.merge_irq_lines) |-> periph_irq == !$past(pc.irq_high))
    else $error("periph interrupt active while merged");
endmodule : uhp_port_props
